//--- pkg/dsr_pkg.sv
`default_nettype none
package dsr_pkg;
  // Function codes
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  // Exception codes
  localparam logic [7:0] EX_NONE       = 8'h00;
  localparam logic [7:0] EX_ILL_FUNC   = 8'h01;
  localparam logic [7:0] EX_ILL_ADDR   = 8'h02;
  localparam logic [7:0] EX_ILL_VALUE  = 8'h03;
  localparam logic [7:0] EX_BUSY       = 8'h06;
  localparam logic [7:0] EX_USER       = 8'h14;
  // Register indices
  localparam logic [15:0] REG_MODEL    = 16'h0000;
  localparam logic [15:0] REG_RATING   = 16'h0001;
  localparam logic [15:0] REG_SUPPLY   = 16'h0002;
  localparam logic [15:0] REG_FWVER    = 16'h0003;
  localparam logic [15:0] REG_WGATE    = 16'h0004;
  localparam logic [15:0] REG_SETPT    = 16'h0005;
  localparam logic [15:0] REG_RUN      = 16'h0006;
  localparam logic [15:0] REG_RAMPUP   = 16'h0007;
  localparam logic [15:0] REG_RAMPDN   = 16'h0008;
  localparam logic [15:0] REG_CURRENT  = 16'h0009;
  localparam logic [15:0] REG_FREQ     = 16'h000a;
  localparam logic [15:0] REG_VOLT     = 16'h000b;
  localparam logic [15:0] REG_BUSV     = 16'h000c;
  localparam logic [15:0] REG_POWER    = 16'h000d;
  localparam logic [15:0] REG_STATE    = 16'h000e;
  localparam logic [15:0] REG_LAST     = 16'h000e;
  // Run control field positions
  localparam int RUN_STOP    = 0;
  localparam int RUN_FWD     = 1;
  localparam int RUN_REV     = 2;
  localparam int RUN_FRESET  = 3;
  localparam int RUN_ESTOP   = 4;
  localparam int RUN_CSRC_LO = 6;
  localparam int RUN_FSRC_LO = 8;
  localparam int RUN_NETERR  = 15;
  localparam logic [15:0] RUN_WR_MASK = 16'h001f;
  // Measurement ceilings, 0.1 V units
  localparam logic [15:0] VOUT_MAX = 16'd6000;
  localparam logic [15:0] VBUS_MAX = 16'd10000;
  // Reset value and firmware version
  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] FW_VER    = 16'h0100;
  // Link loss timeout, in units of 0.1 s
  localparam int  TICK_NS = 100_000_000;
  localparam int  CLK_NS  = 100;
  localparam int  TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [15:0] LOSS_MIN = 16'd1;
  localparam logic [15:0] LOSS_MAX = 16'd1200;
  typedef enum logic [2:0] {
    DSR_IDLE = 3'b001,
    DSR_EXEC = 3'b010,
    DSR_RESP = 3'b100
  } dsr_state_e;
endpackage
`default_nettype wire

//--- logic/dsr_register_map.sv
// Notes on behaviour
// - Serve only function codes 03, 04, 06, 10.
// - Write gate zero rejects writes, except to the gate itself, with 0x14.
// - Read-only or running-locked writes return 0x14.
// - Run bits: stop, forward, reverse requests.
// - Fault reset only on bit 3 rising.
// - Bit 4 emergency stop; bit 5 ignored.
// - Bits 7:6 report command source.
// - Bits 12:8 report frequency-reference source.
// - Bit 15 set on network error.
// - Status bits 0-2: stop, forward, reverse.
// - Status bits 3-5: trip, accel, decel.
// - Status bits 6-7: arrival, DC braking.
// - Status bits 8-9: pre-PID, sleep.
// - Rating register returns hex rating code.
// - Version: major high byte, minor low.
// - Output voltage 0.1 V, up to 600.0.
// - Bus voltage 0.1 V, up to 1000.0.
// - Broadcast run writes act on every drive.
// - Declare link loss after configured timeout.
`timescale 1ns/1ps
`default_nettype none
module dsr_register_map #(
  parameter logic [15:0] MODEL_ID    = 16'h00a5, // Arbitrary value
  parameter logic [15:0] RATING      = 16'h000a,
  parameter logic [15:0] SUPPLY      = 16'h0001,
  parameter int          TICK_CYC    = dsr_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Decoded request from the frame layer
  input  wire logic              req_valid,
  input  wire logic              req_broadcast,
  input  wire logic [7:0]        req_func,
  input  wire logic [15:0]       req_addr,
  input  wire logic [15:0]       req_data,
  input  wire logic              req_last,
  input  wire logic              req_busy,
  input  wire logic              link_activity,
  input  wire logic              link_error,
  // Answer to the frame layer
  output logic                   rsp_valid,
  output logic [7:0]             rsp_exception,
  output logic [15:0]            rsp_data,
  // Drive status inputs
  input  wire logic [9:0]        drive_status,
  input  wire logic [1:0]        cmd_source,
  input  wire logic [4:0]        freq_source,
  input  wire logic              drive_running,
  input  wire logic [15:0]       meas_current,
  input  wire logic [15:0]       meas_freq,
  input  wire logic [15:0]       meas_voltage,
  input  wire logic [15:0]       meas_bus,
  input  wire logic [15:0]       meas_power,
  // Link loss settings
  input  wire logic [15:0]       link_loss_timeout,
  input  wire logic [1:0]        link_loss_action,
  // Commands to the motor control
  output logic                   stop_req,
  output logic                   fwd_req,
  output logic                   rev_req,
  output logic                   estop_req,
  output logic                   fault_reset,
  output logic                   link_lost,
  output logic [1:0]             lost_action,
  output logic [15:0]            speed_setpoint,
  output logic [15:0]            ramp_up_time,
  output logic [15:0]            ramp_down_time
);
  import dsr_pkg::*;

  dsr_state_e  state;
  logic [7:0]  ex_q;
  logic        wr_q;
  logic        bc_q;
  logic [15:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] write_gate;
  logic [15:0] run_control;
  logic        freset_prev;
  logic        net_err;
  logic [31:0] tick_cnt;
  logic [15:0] tenth_cnt;
  logic [1:0]  act_s;
  logic [1:0]  err_s;

  function automatic logic [15:0] clip(input logic [15:0] v,
                                       input logic [15:0] lim);
    clip = (v > lim) ? lim : v;
  endfunction

  function automatic logic is_rw(input logic [15:0] a);
    is_rw = (a == REG_WGATE) || (a == REG_SETPT) || (a == REG_RUN) ||
            (a == REG_RAMPUP) || (a == REG_RAMPDN);
  endfunction

  logic [15:0] status_word;
  assign status_word = {6'h00, drive_status};
  logic [15:0] read_val;
  always_comb begin
    case (addr_q)
      REG_MODEL:   read_val = MODEL_ID;
      REG_RATING:  read_val = RATING;
      REG_SUPPLY:  read_val = SUPPLY;
      REG_FWVER:   read_val = FW_VER;
      REG_WGATE:   read_val = write_gate;
      REG_SETPT:   read_val = speed_setpoint;
      REG_RUN:     read_val = run_control;
      REG_RAMPUP:  read_val = ramp_up_time;
      REG_RAMPDN:  read_val = ramp_down_time;
      REG_CURRENT: read_val = meas_current;
      REG_FREQ:    read_val = meas_freq;
      REG_VOLT:    read_val = clip(meas_voltage, VOUT_MAX);
      REG_BUSV:    read_val = clip(meas_bus, VBUS_MAX);
      REG_POWER:   read_val = meas_power;
      REG_STATE:   read_val = status_word;
      default:     read_val = RST_ZERO;
    endcase
  end

  // Classify the request combinationally; result is captured with it
  logic [7:0] next_ex;
  always_comb begin
    next_ex = EX_NONE;
    if (req_busy) begin
      next_ex = EX_BUSY;
    end else if (req_func != FC_READ_HOLD && req_func != FC_READ_INPUT &&
                 req_func != FC_WRITE_ONE && req_func != FC_WRITE_MANY) begin
      next_ex = EX_ILL_FUNC;
    end else if (req_addr > REG_LAST) begin
      next_ex = EX_ILL_ADDR;
    end else if (req_func == FC_WRITE_ONE || req_func == FC_WRITE_MANY) begin
      if (!is_rw(req_addr)) begin
        next_ex = EX_USER;
      end else if (req_addr == REG_WGATE && req_data > 16'h0001) begin
        next_ex = EX_ILL_VALUE;
      end else if (req_addr != REG_WGATE && write_gate == RST_ZERO) begin
        next_ex = EX_USER;
      end else if (drive_running &&
                   (req_addr == REG_RAMPUP || req_addr == REG_RAMPDN)) begin
        next_ex = EX_USER;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= DSR_IDLE;
      ex_q   <= EX_NONE;
      wr_q   <= 1'b0;
      bc_q   <= 1'b0;
      addr_q <= RST_ZERO;
      data_q <= RST_ZERO;
    end else begin
      case (state)
        DSR_IDLE: begin
          if (req_valid) begin
            ex_q   <= next_ex;
            wr_q   <= (req_func == FC_WRITE_ONE) ||
                      (req_func == FC_WRITE_MANY);
            bc_q   <= req_broadcast;
            addr_q <= req_addr;
            data_q <= req_data;
            state  <= DSR_EXEC;
          end
        end
        DSR_EXEC: state <= DSR_RESP;
        DSR_RESP: state <= DSR_IDLE;
        default:  state <= DSR_IDLE;
      endcase
    end
  end

  wire do_write = (state == DSR_EXEC) && wr_q && (ex_q == EX_NONE);

  // Broadcast writes are applied but never answered
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid     <= 1'b0;
      rsp_exception <= EX_NONE;
      rsp_data      <= RST_ZERO;
    end else begin
      rsp_valid <= (state == DSR_EXEC) && !bc_q;
      if (state == DSR_EXEC) begin
        rsp_exception <= ex_q;
        rsp_data      <= (ex_q == EX_NONE && !wr_q) ? read_val : data_q;
      end
    end
  end

  // Gate stays open until the master closes it
  always_ff @(posedge clk) begin
    if (rst) begin
      write_gate     <= RST_ZERO;
      speed_setpoint <= RST_ZERO;
      ramp_up_time   <= RST_ZERO;
      ramp_down_time <= RST_ZERO;
    end else if (do_write) begin
      if (addr_q == REG_WGATE) write_gate <= data_q;
      if (addr_q == REG_SETPT) speed_setpoint <= data_q;
      if (addr_q == REG_RAMPUP) ramp_up_time <= data_q;
      if (addr_q == REG_RAMPDN) ramp_down_time <= data_q;
    end
  end

  // Upper bits of run control mirror live state, never stored from writes
  logic [4:0] run_cmd;
  always_ff @(posedge clk) begin
    if (rst) begin
      run_cmd <= 5'h00;
    end else if (do_write && addr_q == REG_RUN) begin
      run_cmd <= data_q[4:0];
    end
  end

  always_comb begin
    run_control = RST_ZERO;
    run_control[4:0] = run_cmd & RUN_WR_MASK[4:0];
    run_control[RUN_CSRC_LO +: 2] = cmd_source;
    run_control[RUN_FSRC_LO +: 5] = freq_source;
    run_control[RUN_NETERR] = net_err;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stop_req    <= 1'b0;
      fwd_req     <= 1'b0;
      rev_req     <= 1'b0;
      estop_req   <= 1'b0;
      fault_reset <= 1'b0;
      freset_prev <= 1'b0;
    end else begin
      stop_req    <= run_cmd[RUN_STOP];
      fwd_req     <= run_cmd[RUN_FWD];
      rev_req     <= run_cmd[RUN_REV];
      estop_req   <= run_cmd[RUN_ESTOP];
      freset_prev <= run_cmd[RUN_FRESET];
      fault_reset <= run_cmd[RUN_FRESET] && !freset_prev;
    end
  end

  // Link inputs come from the serial clock region
  always_ff @(posedge clk) begin
    if (rst) begin
      act_s <= 2'b00;
      err_s <= 2'b00;
    end else begin
      act_s <= {act_s[0], link_activity};
      err_s <= {err_s[0], link_error};
    end
  end

  // Error flag: a new error wins over the clear by a run-control write
  always_ff @(posedge clk) begin
    if (rst) begin
      net_err <= 1'b0;
    end else if (err_s[1] || link_lost) begin
      net_err <= 1'b1;
    end else if (do_write && addr_q == REG_RUN) begin
      net_err <= 1'b0;
    end
  end

  // Timeout counted in tenths of a second, clamped to its legal range
  logic [15:0] loss_lim;
  assign loss_lim = clip((link_loss_timeout < LOSS_MIN) ? LOSS_MIN :
                         link_loss_timeout, LOSS_MAX);
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt    <= 32'h0;
      tenth_cnt   <= RST_ZERO;
      link_lost   <= 1'b0;
      lost_action <= 2'b00;
    end else if (act_s[1]) begin
      tick_cnt  <= 32'h0;
      tenth_cnt <= RST_ZERO;
      link_lost <= 1'b0;
    end else if (!link_lost) begin
      if (tick_cnt == 32'(TICK_CYC - 1)) begin
        tick_cnt  <= 32'h0;
        tenth_cnt <= tenth_cnt + 16'h0001;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
      if (tenth_cnt >= loss_lim) begin
        link_lost   <= 1'b1;
        lost_action <= link_loss_action;
      end
    end
  end

  // Assertions
  property p_fc_filter;
    @(posedge clk) disable iff (rst)
      (state == DSR_IDLE && req_valid && !req_busy &&
       req_func == 8'h05) |=> ##1 (rsp_exception == EX_ILL_FUNC || bc_q);
  endproperty
  a_fc_filter: assert property (p_fc_filter) else $error("bad fc");

  property p_gate_closed;
    @(posedge clk) disable iff (rst)
      (state == DSR_EXEC && wr_q && write_gate == RST_ZERO &&
       addr_q == REG_SETPT && ex_q != EX_BUSY) |=>
       $stable(speed_setpoint) && rsp_exception == EX_USER;
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("gate");

  property p_ro_write;
    @(posedge clk) disable iff (rst)
      (state == DSR_EXEC && wr_q && !is_rw(addr_q) &&
       addr_q <= REG_LAST && ex_q != EX_BUSY) |=> rsp_exception == EX_USER;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro write");

  property p_reset_edge;
    @(posedge clk) disable iff (rst)
      fault_reset |=> !fault_reset;
  endproperty
  a_reset_edge: assert property (p_reset_edge)
    else $error("fr pulse");

  property p_reset_cause;
    @(posedge clk) disable iff (rst)
      fault_reset |-> $past(run_cmd[RUN_FRESET]) && !$past(freset_prev);
  endproperty
  a_reset_cause: assert property (p_reset_cause)
    else $error("fr cause");

  property p_run_bits;
    @(posedge clk) disable iff (rst)
      do_write && addr_q == REG_RUN |-> ##2
        fwd_req == $past(data_q[RUN_FWD], 2) &&
        estop_req == $past(data_q[RUN_ESTOP], 2);
  endproperty
  a_run_bits: assert property (p_run_bits) else $error("run bits");

  property p_neterr;
    @(posedge clk) disable iff (rst)
      err_s[1] |=> run_control[RUN_NETERR];
  endproperty
  a_neterr: assert property (p_neterr) else $error("net err");

  property p_vclip;
    @(posedge clk) disable iff (rst)
      state == DSR_EXEC && addr_q == REG_VOLT && !wr_q && ex_q == EX_NONE
      |=> rsp_data <= VOUT_MAX;
  endproperty
  a_vclip: assert property (p_vclip) else $error("vout clip");

  property p_broadcast;
    @(posedge clk) disable iff (rst)
      state == DSR_EXEC && bc_q |=> !rsp_valid;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("bcast");
endmodule
`default_nettype wire

//--- tb/dsr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_master_model (
  // Clock
  input  wire logic        clk,
  // Answer from the map
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_exception,
  input  wire logic [15:0] rsp_data,
  // Request to the map
  output logic             req_valid,
  output logic             req_broadcast,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_data,
  output logic             req_last
);
  logic        got_rsp;
  logic [7:0]  got_ex;
  logic [15:0] got_data;
  initial begin
    req_valid     = 1'b0;
    req_broadcast = 1'b0;
    req_func      = 8'h00;
    req_addr      = 16'h0000;
    req_data      = 16'h0000;
    req_last      = 1'b0;
  end
  // One word per request; entered just after a falling edge
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, input logic bc);
    got_rsp       = 1'b0;
    got_ex        = 8'hxx;
    got_data      = 16'hxxxx;
    req_valid     = 1'b1;
    req_broadcast = bc;
    req_func      = f;
    req_addr      = a;
    req_data      = d;
    req_last      = 1'b1;
    @(negedge clk);
    req_valid     = 1'b0;
    req_broadcast = 1'b0;
    req_last      = 1'b0;
    // Released fields show the inverse so stale data cannot pass
    req_func      = ~f;
    req_addr      = ~a;
    req_data      = ~d;
    // Four idle cycles keep requests well over three cycles apart
    repeat (4) begin
      @(negedge clk);
      if (!got_rsp && rsp_valid === 1'b1) begin
        got_rsp  = 1'b1;
        got_ex   = rsp_exception;
        got_data = rsp_data;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/drive_serial_register_map_test.sv
`timescale 1ns/1ps
`default_nettype none
module drive_serial_register_map_test;
  import dsr_pkg::*;
  localparam logic [15:0] MODEL_VAL = 16'h0033; // Arbitrary value
  localparam logic [15:0] RATE_VAL  = 16'h000b;
  localparam logic [15:0] RV [5] = '{16'h0001, 16'h0002, 16'h0004,
                                     16'h0010, 16'h0020};
  logic        clk = 1'b0, rst = 1'b1;
  logic        req_valid, req_broadcast, req_last, rsp_valid;
  logic [7:0]  req_func, rsp_exception;
  logic [15:0] req_addr, req_data, rsp_data;
  logic        req_busy = 1'b0, link_activity = 1'b1;
  logic        link_error = 1'b0, drive_running = 1'b0;
  logic [9:0]  drive_status = 10'h000;
  logic [1:0]  cmd_source = 2'h0, link_loss_action = 2'h2, lost_action;
  logic [4:0]  freq_source = 5'h00;
  logic [15:0] meas_current = 16'h0123, meas_freq = 16'h1770;
  logic [15:0] meas_voltage = 16'h0000, meas_bus = 16'h0000;
  logic [15:0] meas_power = 16'h0042, link_loss_timeout = 16'h0002;
  logic        stop_req, fwd_req, rev_req, estop_req, fault_reset;
  logic        link_lost;
  logic [15:0] speed_setpoint, ramp_up_time, ramp_down_time;
  int          n_mismatch = 0, samples_checked = 0, n_freset = 0;

  always #50 clk = ~clk;
  // Sampled mid-cycle so the pulse is seen where it has settled
  always @(negedge clk) begin
    if (fault_reset === 1'b1) begin
      n_freset <= n_freset + 1;
    end
  end

  dsr_register_map #(
    .MODEL_ID (MODEL_VAL),
    .RATING   (RATE_VAL),
    .SUPPLY   (16'h0001),
    .TICK_CYC (10)
  ) dut_u (
    .clk, .rst, .req_valid, .req_broadcast, .req_func, .req_addr,
    .req_data, .req_last, .req_busy, .link_activity, .link_error,
    .rsp_valid, .rsp_exception, .rsp_data, .drive_status, .cmd_source,
    .freq_source, .drive_running, .meas_current, .meas_freq,
    .meas_voltage, .meas_bus, .meas_power, .link_loss_timeout,
    .link_loss_action, .stop_req, .fwd_req, .rev_req, .estop_req,
    .fault_reset, .link_lost, .lost_action, .speed_setpoint,
    .ramp_up_time, .ramp_down_time
  );
  dsr_master_model master_u (
    .clk, .rsp_valid, .rsp_exception, .rsp_data, .req_valid,
    .req_broadcast, .req_func, .req_addr, .req_data, .req_last
  );

  task automatic chk_word(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ex(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [7:0] f, input logic [15:0] a, d,
                     input logic [7:0] ex);
    master_u.xfer(f, a, d, 1'b0);
    chk_ex("exception", ex, master_u.got_ex);
  endtask
  task automatic rd(input logic [15:0] a, e);
    acc(FC_READ_HOLD, a, 16'h0000, EX_NONE);
    chk_word("read data", e, master_u.got_data);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    close_out;
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk_word("run outputs", 16'h0000, {11'h0, stop_req, fwd_req,
             rev_req, estop_req, fault_reset});
    rd(REG_MODEL, MODEL_VAL);
    rd(REG_RATING, 16'h000b);
    acc(FC_READ_INPUT, REG_FWVER, 16'h0000, EX_NONE);
    chk_word("version", 16'h0100, master_u.got_data);
    rd(REG_SUPPLY, 16'h0001);
    acc(FC_WRITE_ONE, REG_SETPT, 16'h1234, EX_USER);
    rd(REG_SETPT, 16'h0000);
    acc(FC_WRITE_ONE, REG_WGATE, 16'h0002, EX_ILL_VALUE);
    acc(FC_WRITE_ONE, REG_WGATE, 16'h0001, EX_NONE);
    rd(REG_WGATE, 16'h0001);
    acc(FC_WRITE_MANY, REG_SETPT, 16'h1234, EX_NONE);
    chk_word("setpoint", 16'h1234, speed_setpoint);
    acc(8'h05, REG_SETPT, 16'h0000, EX_ILL_FUNC);
    acc(FC_READ_HOLD, 16'h000f, 16'h0000, EX_ILL_ADDR);
    req_busy = 1'b1;
    acc(FC_READ_HOLD, REG_MODEL, 16'h0000, EX_BUSY);
    req_busy = 1'b0;
    acc(FC_WRITE_ONE, REG_RATING, 16'h0001, EX_USER);
    drive_running = 1'b1;
    acc(FC_WRITE_ONE, REG_RAMPUP, 16'h0050, EX_USER);
    drive_running = 1'b0;
    acc(FC_WRITE_ONE, REG_RAMPUP, 16'h0050, EX_NONE);
    chk_word("ramp up", 16'h0050, ramp_up_time);
    acc(FC_WRITE_MANY, REG_RAMPDN, 16'h0060, EX_NONE);
    chk_word("ramp down", 16'h0060, ramp_down_time);
    rd(REG_RAMPDN, 16'h0060);
    for (int i = 0; i < 5; i++) begin
      acc(FC_WRITE_ONE, REG_RUN, RV[i], EX_NONE);
      chk_word("run requests", {12'h0, RV[i][4], RV[i][2:0]},
               {12'h0, estop_req, rev_req, fwd_req, stop_req});
    end
    // A held bit must not repeat the reset pulse
    acc(FC_WRITE_ONE, REG_RUN, 16'h0008, EX_NONE);
    acc(FC_WRITE_ONE, REG_RUN, 16'h0008, EX_NONE);
    chk_word("fault resets", 16'h0001, 16'(n_freset));
    cmd_source = 2'h3;
    freq_source = 5'd28;
    link_error = 1'b1;
    repeat (4) @(negedge clk);
    link_error = 1'b0;
    rd(REG_RUN, 16'h9cc8);
    acc(FC_WRITE_ONE, REG_RUN, 16'h0000, EX_NONE);
    rd(REG_RUN, 16'h1cc0);
    cmd_source = 2'h1;
    freq_source = 5'd31;
    rd(REG_RUN, 16'h1f40);
    for (int i = 0; i < 10; i++) begin
      drive_status = 10'h001 << i;
      rd(REG_STATE, 16'h0001 << i);
    end
    meas_voltage = 16'd7000;
    meas_bus = 16'd12000;
    rd(REG_VOLT, 16'd6000);
    rd(REG_BUSV, 16'd10000);
    meas_voltage = 16'd5999;
    meas_bus = 16'd9999;
    rd(REG_VOLT, 16'd5999);
    rd(REG_BUSV, 16'd9999);
    rd(REG_CURRENT, 16'h0123);
    rd(REG_FREQ, 16'h1770);
    rd(REG_POWER, 16'h0042);
    master_u.xfer(FC_WRITE_ONE, REG_RUN, 16'h0002, 1'b1);
    chk_word("bcast answer", 16'h0000, {15'h0, master_u.got_rsp});
    chk_word("forward", 16'h0001, {15'h0, fwd_req});
    link_activity = 1'b0;
    repeat (5) @(negedge clk);
    chk_word("link lost", 16'h0000, {15'h0, link_lost});
    repeat (40) @(negedge clk);
    chk_word("link lost", 16'h0001, {15'h0, link_lost});
    chk_word("loss action", 16'h0002, {14'h0, lost_action});
    rd(REG_RUN, 16'h9f42);
    // Closing the gate again must block parameter writes
    acc(FC_WRITE_ONE, REG_WGATE, 16'h0000, EX_NONE);
    acc(FC_WRITE_ONE, REG_SETPT, 16'h5555, EX_USER);
    chk_word("setpoint", 16'h1234, speed_setpoint);
    close_out;
  end
endmodule
`default_nettype wire
